// >>> verilog/sbmc_pkg.sv
// Constants and types shared by the system bus mode controller.
`default_nettype none
package sbmc_pkg;
  // Register offsets on the plain register port.
  localparam logic [3:0] SBMC_OFS_MODE   = 4'h0;
  localparam logic [3:0] SBMC_OFS_WAIT   = 4'h1;
  localparam logic [3:0] SBMC_OFS_RDAT0  = 4'h2;
  localparam logic [3:0] SBMC_OFS_RDAT1  = 4'h3;
  localparam logic [3:0] SBMC_OFS_RDAT2  = 4'h4;
  localparam logic [3:0] SBMC_OFS_CSDAT  = 4'h5;
  localparam logic [3:0] SBMC_OFS_PDAT   = 4'h6;
  localparam logic [3:0] SBMC_OFS_PDIR   = 4'h7;
  localparam logic [3:0] SBMC_OFS_STATUS = 4'h8;
  // Field positions of the mode register.
  localparam int SBMC_BIT_BUS_EXP = 7;
  localparam int SBMC_BIT_CPU_MAX = 6;
  // Field positions of the status register.
  localparam int SBMC_BIT_EXT_BOOT = 0;
  localparam int SBMC_BIT_BUSY     = 1;
  // Values after reset.
  localparam logic [7:0] SBMC_RST_RDAT  = 8'hff;
  localparam logic [5:0] SBMC_RST_RDAT2 = 6'h3f;
  localparam logic [2:0] SBMC_RST_CSDAT = 3'h7;
  localparam logic [7:0] SBMC_RST_PDAT  = 8'hff;
  localparam logic [7:0] SBMC_RST_PDIR  = 8'h00;
  localparam logic [2:0] SBMC_RST_WAIT  = 3'h0;
  // Chip select windows, upper address bits, internal boot.
  localparam logic [1:0] SBMC_CS0_INT_TOP = 2'h3;
  localparam logic [1:0] SBMC_CS1_TOP     = 2'h1;
  localparam logic [1:0] SBMC_CS2_TOP     = 2'h2;
  // Chip select zero windows for external boot.
  localparam logic [21:0] SBMC_CS0_EXT_LO_END = 22'h00d7ff;
  localparam logic [21:0] SBMC_CS0_EXT_HI_BEG = 22'h010000;
  localparam logic [21:0] SBMC_CS0_EXT_HI_END = 22'h0fffff;
  // Strobe bit positions in the flat R pin vector, just above the twenty address bits.
  localparam int SBMC_PIN_RD = 20;
  localparam int SBMC_PIN_WR = 21;
  // External bus cycle states.
  typedef enum logic [2:0]
  {
    SBMC_ST_IDLE = 3'b000,
    SBMC_ST_T1   = 3'b001,
    SBMC_ST_T2   = 3'b010,
    SBMC_ST_T3   = 3'b011,
    SBMC_ST_WAIT = 3'b100,
    SBMC_ST_T4   = 3'b101
  } sbmc_state_e;
endpackage
`default_nettype wire

// >>> verilog/sbmc_wait_timer.sv
// Countdown of wait cycles inserted between the third and fourth bus states.
`default_nettype none
module sbmc_wait_timer
  import sbmc_pkg::*;
(
  input  wire logic       clk,    // CPU clock
  input  wire logic       nrst,   // Asynchronous reset, active low
  input  wire logic       load,   // Load the count
  input  wire logic [2:0] ld_val, // Wait cycles to run
  output var  logic [2:0] rem     // Cycles still to run
);
  typedef struct packed
  {
    logic [2:0] rem;
  } sbmc_tmr_s;

  sbmc_tmr_s t_reg;
  sbmc_tmr_s t_next;

  // Every count of two half-cycle states is one whole clock cycle.
  always_comb
  begin
    t_next = t_reg;
    if (load)
    begin
      t_next.rem = ld_val;
    end
    else if (t_reg.rem != 3'h0)
    begin
      t_next.rem = t_reg.rem - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      t_reg <= '0;
    end
    else
    begin
      t_reg <= t_next;
    end
  end

  assign rem = t_reg.rem;
endmodule
`default_nettype wire

// >>> verilog/sbmc_ctrl.sv
// System bus mode controller: mode bits, pin reuse, chip selects and wait states.
// What this block does
// - Software bits pick expansion or single chip, and maximum or minimum CPU mode.
// - Exactly two bus modes and two CPU modes exist, one bit each.
// - Internal boot resets to single chip, minimum mode, running from internal ROM.
// - External boot resets to expansion, minimum mode.
// - External boot disables internal program ROM; fetches go outside.
// - Expansion turns R pins into address and strobes, P pins into data.
// - Address decoders drive up to three chip select outputs.
// - Internal boot windows: select zero 3xxxxx, one 1xxxxx, two 2xxxxx.
// - External boot: select zero covers 000000-00D7FF and 010000-0FFFFF.
// - Select pins start as port pins until software sets their enable bit.
// - A select is active only for external accesses to its own window.
// - Three-bit wait field gives twice its value in half-cycle states.
// - Each wait state lasts half a CPU clock cycle.
// - Wait states sit between the third and fourth bus states.
// - No waits for internal accesses or while on the sub oscillator.
// - In single chip mode the wait field has no effect.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`default_nettype none
module sbmc_ctrl
  import sbmc_pkg::*;
(
  input  wire logic        clk,                 // CPU clock, 25 MHz
  input  wire logic        nrst,                // Asynchronous reset, active low
  input  wire logic        boot_source_pin,     // 1 internal boot, 0 external boot
  input  wire logic        sub_oscillator,      // CPU runs on the sub oscillator
  input  wire logic [3:0]  reg_addr,            // Register address
  input  wire logic [7:0]  reg_wdata,           // Register write data
  input  wire logic        reg_wr,              // Register write strobe
  input  wire logic        reg_rd,              // Register read strobe
  output var  logic [7:0]  reg_rdata,           // Register read data, next cycle
  input  wire logic        cpu_req,             // Core access request pulse
  input  wire logic        cpu_wr,              // Access is a write
  input  wire logic [21:0] cpu_addr,            // Access address
  input  wire logic [7:0]  cpu_wdata,           // Write data
  input  wire logic        cpu_int_hit,         // Address hits internal RAM or registers
  input  wire logic        cpu_rom_hit,         // Address hits internal program ROM
  output var  logic        cpu_ack,             // Access done pulse
  output var  logic [7:0]  cpu_rdata,           // External read data
  output var  logic        cpu_max_mode,        // Maximum CPU mode selected
  output var  logic        int_rom_en,          // Internal program ROM enabled
  output var  logic [21:0] r_pin_out,           // R00-R07, R10-R17, R20-R25 pin levels
  input  wire logic [7:0]  p_pin_in,            // P00-P07 pin levels
  output var  logic [7:0]  p_pin_out,           // P00-P07 drive value
  output var  logic [7:0]  p_pin_oe,            // P00-P07 drive enables
  output var  logic        chip_select_zero_n,  // Chip select zero pin
  output var  logic        chip_select_one_n,   // Chip select one pin
  output var  logic        chip_select_two_n    // Chip select two pin
);
  typedef struct packed
  {
    sbmc_state_e st;
    logic        strap_done;
    logic        ext_boot;
    logic        bus_exp;
    logic        cpu_max;
    logic [2:0]  cs_en;
    logic [2:0]  wcode;
    logic [7:0]  r0;
    logic [7:0]  r1;
    logic [5:0]  r2;
    logic [2:0]  r3;
    logic [7:0]  p0;
    logic [7:0]  pdir;
    logic [7:0]  rdata;
    logic [21:0] addr;
    logic        wr_l;
    logic [7:0]  wd;
    logic [2:0]  wused;
    logic        ack;
    logic [7:0]  crdata;
    logic [21:0] r_out;
    logic [7:0]  p_out;
    logic [7:0]  p_oe;
    logic [2:0]  cs_out;
    logic        rom_en;
  } sbmc_ctrl_s;

  sbmc_ctrl_s s_reg;
  sbmc_ctrl_s s_next;
  logic [2:0] wait_rem;
  logic       ext_acc;
  logic       strobe_on;

  // Address window test for one chip select.
  function automatic logic cs_hit(input logic [21:0] a, input int idx, input logic ext);
    logic r;
    r = 1'b0;
    case (idx)
      0: r = ext ? ((a <= SBMC_CS0_EXT_LO_END) ||
                    (a >= SBMC_CS0_EXT_HI_BEG && a <= SBMC_CS0_EXT_HI_END))
                 : (a[21:20] == SBMC_CS0_INT_TOP);
      1: r = (a[21:20] == SBMC_CS1_TOP);
      2: r = (a[21:20] == SBMC_CS2_TOP);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  sbmc_wait_timer u_wait
  (
    .clk    (clk),
    .nrst   (nrst),
    .load   (s_reg.st == SBMC_ST_T2),
    .ld_val (sub_oscillator ? 3'h0 : s_reg.wcode),
    .rem    (wait_rem)
  );

  always_comb
  begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    // Strap is caught on the first edge after reset release.
    if (!s_reg.strap_done)
    begin
      s_next.strap_done = 1'b1;
      s_next.ext_boot = !boot_source_pin;
      s_next.bus_exp = !boot_source_pin;
      s_next.cpu_max = 1'b0;
    end
    if (reg_wr)
    begin
      case (reg_addr)
        SBMC_OFS_MODE:
        begin
          // External boot keeps the bus in expansion mode.
          s_next.bus_exp = s_reg.ext_boot | reg_wdata[SBMC_BIT_BUS_EXP];
          s_next.cpu_max = reg_wdata[SBMC_BIT_CPU_MAX];
          s_next.cs_en = reg_wdata[2:0];
        end
        SBMC_OFS_WAIT:  s_next.wcode = reg_wdata[2:0];
        SBMC_OFS_RDAT0: s_next.r0 = reg_wdata;
        SBMC_OFS_RDAT1: s_next.r1 = reg_wdata;
        SBMC_OFS_RDAT2: s_next.r2 = reg_wdata[5:0];
        SBMC_OFS_CSDAT: s_next.r3 = reg_wdata[2:0];
        SBMC_OFS_PDAT:  s_next.p0 = reg_wdata;
        SBMC_OFS_PDIR:  s_next.pdir = reg_wdata;
        default:        s_next.r3 = s_next.r3;
      endcase
    end
    s_next.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        SBMC_OFS_MODE:   s_next.rdata = {s_reg.bus_exp, s_reg.cpu_max, 3'h0, s_reg.cs_en};
        SBMC_OFS_WAIT:   s_next.rdata = {5'h00, s_reg.wcode};
        SBMC_OFS_RDAT0:  s_next.rdata = s_reg.r0;
        SBMC_OFS_RDAT1:  s_next.rdata = s_reg.r1;
        SBMC_OFS_RDAT2:  s_next.rdata = {2'h0, s_reg.r2};
        SBMC_OFS_CSDAT:  s_next.rdata = {5'h00, s_reg.r3};
        SBMC_OFS_PDAT:   s_next.rdata = s_reg.p0;
        SBMC_OFS_PDIR:   s_next.rdata = s_reg.pdir;
        SBMC_OFS_STATUS: s_next.rdata = {6'h00, s_reg.st != SBMC_ST_IDLE, s_reg.ext_boot};
        default:         s_next.rdata = 8'h00;
      endcase
    end
    // Internal ROM counts as internal only under internal boot.
    ext_acc = s_reg.bus_exp && !(cpu_int_hit || (cpu_rom_hit && !s_reg.ext_boot));
    case (s_reg.st)
      SBMC_ST_IDLE:
      begin
        if (cpu_req && ext_acc)
        begin
          s_next.st = SBMC_ST_T1;
          s_next.addr = cpu_addr;
          s_next.wr_l = cpu_wr;
          s_next.wd = cpu_wdata;
        end
        else if (cpu_req)
        begin
          s_next.ack = 1'b1;
        end
      end
      SBMC_ST_T1: s_next.st = SBMC_ST_T2;
      SBMC_ST_T2:
      begin
        s_next.st = SBMC_ST_T3;
        s_next.wused = sub_oscillator ? 3'h0 : s_reg.wcode;
      end
      SBMC_ST_T3: s_next.st = (wait_rem == 3'h0) ? SBMC_ST_T4 : SBMC_ST_WAIT;
      SBMC_ST_WAIT: s_next.st = (wait_rem == 3'h0) ? SBMC_ST_T4 : SBMC_ST_WAIT;
      SBMC_ST_T4:
      begin
        s_next.st = SBMC_ST_IDLE;
        s_next.ack = 1'b1;
        if (!s_reg.wr_l)
        begin
          s_next.crdata = p_pin_in;
        end
      end
      default: s_next.st = SBMC_ST_IDLE;
    endcase
    // Pin levels follow the next state so they line up with it.
    strobe_on = (s_next.st == SBMC_ST_T2) || (s_next.st == SBMC_ST_T3) ||
                (s_next.st == SBMC_ST_WAIT) || (s_next.st == SBMC_ST_T4);
    if (s_next.bus_exp)
    begin
      s_next.r_out = {!(strobe_on && s_next.wr_l), !(strobe_on && !s_next.wr_l),
                      s_next.addr[19:0]};
      s_next.p_out = s_next.wd;
      s_next.p_oe = (strobe_on && s_next.wr_l) ? 8'hff : 8'h00;
    end
    else
    begin
      s_next.r_out = {s_next.r2, s_next.r1, s_next.r0};
      s_next.p_out = s_next.p0;
      s_next.p_oe = s_next.pdir;
    end
    for (int i = 0; i < 3; i++)
    begin
      if (s_next.bus_exp && s_next.cs_en[i])
      begin
        s_next.cs_out[i] = !((s_next.st != SBMC_ST_IDLE) &&
                             cs_hit(s_next.addr, i, s_next.ext_boot));
      end
      else
      begin
        s_next.cs_out[i] = s_next.r3[i];
      end
    end
    s_next.rom_en = !s_next.ext_boot;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_reg <= '0;
      s_reg.wcode <= SBMC_RST_WAIT;
      s_reg.r0 <= SBMC_RST_RDAT;
      s_reg.r1 <= SBMC_RST_RDAT;
      s_reg.r2 <= SBMC_RST_RDAT2;
      s_reg.r3 <= SBMC_RST_CSDAT;
      s_reg.p0 <= SBMC_RST_PDAT;
      s_reg.pdir <= SBMC_RST_PDIR;
      s_reg.r_out <= {SBMC_RST_RDAT2, SBMC_RST_RDAT, SBMC_RST_RDAT};
      s_reg.p_out <= SBMC_RST_PDAT;
      s_reg.cs_out <= SBMC_RST_CSDAT;
      s_reg.rom_en <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign cpu_ack = s_reg.ack;
  assign cpu_rdata = s_reg.crdata;
  assign cpu_max_mode = s_reg.cpu_max;
  assign int_rom_en = s_reg.rom_en;
  assign r_pin_out = s_reg.r_out;
  assign p_pin_out = s_reg.p_out;
  assign p_pin_oe = s_reg.p_oe;
  assign chip_select_zero_n = s_reg.cs_out[0];
  assign chip_select_one_n = s_reg.cs_out[1];
  assign chip_select_two_n = s_reg.cs_out[2];

  // Counts whole cycles spent in the wait state for checking.
  logic [3:0] wcnt;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wcnt <= 4'h0;
    end
    else
    begin
      wcnt <= (s_reg.st == SBMC_ST_WAIT) ? wcnt + 4'h1 : 4'h0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence boot_seen;
    $rose(s_reg.strap_done);
  endsequence

  AST_BOOT_INT: assert property (boot_seen and !s_reg.ext_boot |-> !s_reg.bus_exp && !s_reg.cpu_max)
    else $error("internal boot did not start in single chip minimum mode");
  AST_BOOT_EXT: assert property (boot_seen and s_reg.ext_boot |->
                                 s_reg.bus_exp && !s_reg.cpu_max && !int_rom_en)
    else $error("external boot did not start in expansion minimum mode with ROM off");
  AST_WAIT_LEN: assert property ((s_reg.st == SBMC_ST_WAIT) ##1 (s_reg.st == SBMC_ST_T4) |->
                                 {1'b0, s_reg.wused} == wcnt)
    else $error("wait length differs from programmed count");
  AST_NO_WAIT_SUB: assert property ((s_reg.st == SBMC_ST_T2) && sub_oscillator |=>
                                    (s_reg.st == SBMC_ST_T3) ##1 (s_reg.st == SBMC_ST_T4))
    else $error("wait inserted while on sub oscillator");
  AST_SINGLE_IDLE: assert property (!s_reg.bus_exp && (s_reg.st == SBMC_ST_IDLE) |=>
                                    (s_reg.st == SBMC_ST_IDLE))
    else $error("external bus cycle in single chip mode");
  AST_PINS_SINGLE: assert property (!s_reg.bus_exp |-> r_pin_out == {s_reg.r2, s_reg.r1, s_reg.r0})
    else $error("R pins not port data in single chip mode");
  AST_STROBE_HOLD: assert property ((s_reg.st == SBMC_ST_WAIT) |->
                                    (r_pin_out[SBMC_PIN_RD] == s_reg.wr_l) && (r_pin_out[SBMC_PIN_WR] == !s_reg.wr_l))
    else $error("strobe released during wait");
  AST_CS_IDLE: assert property ((s_reg.st == SBMC_ST_IDLE) && s_reg.bus_exp && (s_reg.cs_en == 3'h7) |->
                                s_reg.cs_out == 3'h7)
    else $error("chip select active outside an external access");
  AST_CS1_DECODE: assert property ((s_reg.st == SBMC_ST_T1) && s_reg.bus_exp && s_reg.cs_en[1] |->
                                   chip_select_one_n == (s_reg.addr[21:20] != SBMC_CS1_TOP))
    else $error("chip select one decode wrong");
  AST_CS0_EXT: assert property ((s_reg.st == SBMC_ST_T1) && s_reg.ext_boot && s_reg.cs_en[0] &&
                                (s_reg.addr <= SBMC_CS0_EXT_LO_END) |-> !chip_select_zero_n)
    else $error("chip select zero missing for external boot low window");

  // Steps of one external bus cycle, shared by the checks below.
  sequence ext_start;
    (s_reg.st == SBMC_ST_IDLE) && cpu_req && ext_acc;
  endsequence

  sequence head_states;
    (s_reg.st == SBMC_ST_T1) ##1 (s_reg.st == SBMC_ST_T2) ##1 (s_reg.st == SBMC_ST_T3);
  endsequence

  sequence tail_states;
    (s_reg.st == SBMC_ST_T4) ##1 (cpu_ack && (s_reg.st == SBMC_ST_IDLE));
  endsequence

  AST_CYCLE_HEAD: assert property (ext_start |=> head_states)
    else $error("external bus cycle did not open with its first three states");
  AST_WAIT_ENTRY: assert property ((s_reg.st == SBMC_ST_T3) && (s_reg.wused != 3'h0) |=>
                                   (s_reg.st == SBMC_ST_WAIT))
    else $error("programmed wait not entered after the third state");
  AST_NO_WAIT_ZERO: assert property ((s_reg.st == SBMC_ST_T3) && (s_reg.wused == 3'h0) |=> tail_states)
    else $error("wait inserted with a zero wait code");
  AST_WAIT_EXIT: assert property ((s_reg.st == SBMC_ST_WAIT) && (wait_rem == 3'h0) |=> tail_states)
    else $error("bus cycle did not close after the last wait cycle");
  AST_INT_ACK: assert property ((s_reg.st == SBMC_ST_IDLE) && cpu_req && !ext_acc |=>
                                cpu_ack && (s_reg.st == SBMC_ST_IDLE))
    else $error("internal access not answered at once");

  // Pin behaviour in expansion mode, and the external boot lock.
  AST_STROBE_EXCL: assert property (s_reg.bus_exp |-> r_pin_out[SBMC_PIN_RD] || r_pin_out[SBMC_PIN_WR])
    else $error("read and write strobes active together");
  AST_STROBE_IDLE: assert property ((s_reg.st == SBMC_ST_IDLE) && s_reg.bus_exp |->
                                    r_pin_out[SBMC_PIN_RD] && r_pin_out[SBMC_PIN_WR])
    else $error("strobe active while the bus is idle");
  AST_DATA_DRIVE: assert property ((s_reg.st == SBMC_ST_WAIT) && s_reg.bus_exp && s_reg.wr_l |->
                                   (p_pin_oe == 8'hff) && (p_pin_out == s_reg.wd))
    else $error("write data not driven during wait");
  AST_DATA_FLOAT: assert property (s_reg.bus_exp && !s_reg.wr_l |-> p_pin_oe == 8'h00)
    else $error("data bus driven outside a write");
  AST_EXT_LOCK: assert property (s_reg.ext_boot |-> s_reg.bus_exp && !int_rom_en)
    else $error("external boot left expansion mode or enabled internal ROM");

  // Chip select decoding and port use.
  AST_CS_INT_NONE: assert property ((s_reg.st == SBMC_ST_IDLE) && s_reg.bus_exp && cpu_req && !ext_acc &&
                                    !reg_wr && (s_reg.cs_en == 3'h7) |=> s_reg.cs_out == 3'h7)
    else $error("chip select active for an internal access");
  AST_CS0_INT_DECODE: assert property ((s_reg.st == SBMC_ST_T1) && s_reg.bus_exp && !s_reg.ext_boot &&
                                       s_reg.cs_en[0] |-> chip_select_zero_n == (s_reg.addr[21:20] != SBMC_CS0_INT_TOP))
    else $error("chip select zero decode wrong");
  AST_CS2_DECODE: assert property ((s_reg.st == SBMC_ST_T1) && s_reg.bus_exp && s_reg.cs_en[2] |->
                                   chip_select_two_n == (s_reg.addr[21:20] != SBMC_CS2_TOP))
    else $error("chip select two decode wrong");
  AST_CS_PORT: assert property (!(s_reg.bus_exp && s_reg.cs_en[0]) |-> chip_select_zero_n == s_reg.r3[0])
    else $error("chip select zero pin not following its port data");
endmodule
`default_nettype wire

// >>> verification/sbmc_mem_model.sv
// Behavioural external ROM and RAM sitting on the expansion bus.
`default_nettype none
module sbmc_mem_model
  import sbmc_pkg::*;
(
  input  wire logic        clk,    // CPU clock
  input  wire logic [21:0] r_pins, // Address and strobe pins
  input  wire logic [7:0]  d_out,  // Data driven by the controller
  input  wire logic [7:0]  d_oe,   // Data drive enables
  input  wire logic [2:0]  sel_n,  // Chip selects, active low
  output var  logic [7:0]  d_in    // Data seen by the controller
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  logic       picked;
  logic [7:0] idx;
  assign picked = ~&sel_n;
  assign idx    = r_pins[7:0];
  // The data bus has no pull, so a released bus shows a value that flips every cycle.
  always_comb
  begin
    if (picked && !r_pins[SBMC_PIN_RD])
      d_in = mem[idx];
    else
      d_in = ~last;
  end
  always @(posedge clk)
  begin
    last <= d_in;
    if (picked && !r_pins[SBMC_PIN_WR] && d_oe == 8'hff)
      mem[idx] <= d_out;
  end
endmodule
`default_nettype wire

// >>> verification/sbmc_ctrl_tb.sv
// Self-checking bench for the system bus mode controller.
`default_nettype none
module sbmc_ctrl_tb
  import sbmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, boot_source_pin, sub_oscillator, reg_wr, reg_rd, cpu_req, cpu_wr, cpu_int_hit;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, cpu_wdata, cpu_rdata, p_pin_in, p_pin_out, p_pin_oe;
  logic [21:0] cpu_addr;
  logic        cpu_ack, cpu_max_mode, int_rom_en, cs0_n, cs1_n, cs2_n, cpu_rom_hit;
  logic [21:0] r_pin_out;
  int          n_errors = 0;
  int          checked = 0;
  sbmc_ctrl u_sbmc_ctrl (.clk(clk), .nrst(nrst), .boot_source_pin(boot_source_pin),
    .sub_oscillator(sub_oscillator), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_req(cpu_req), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_int_hit(cpu_int_hit), .cpu_rom_hit(cpu_rom_hit), .cpu_ack(cpu_ack),
    .cpu_rdata(cpu_rdata), .cpu_max_mode(cpu_max_mode), .int_rom_en(int_rom_en), .r_pin_out(r_pin_out),
    .p_pin_in(p_pin_in), .p_pin_out(p_pin_out), .p_pin_oe(p_pin_oe), .chip_select_zero_n(cs0_n),
    .chip_select_one_n(cs1_n), .chip_select_two_n(cs2_n));
  sbmc_mem_model u_sbmc_mem_model (.clk(clk), .r_pins(r_pin_out), .d_out(p_pin_out), .d_oe(p_pin_oe),
    .sel_n({cs2_n, cs1_n, cs0_n}), .d_in(p_pin_in));
  always #20 clk = ~clk;
  task automatic chk(input logic [25:0] got, input logic [25:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude;
    $display("Summary: %0d mismatches in %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic do_reset(input logic boot);
    @(posedge clk);
    nrst            <= 1'b0;
    boot_source_pin <= boot;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({18'h0, reg_rdata}, {18'h0, exp}, what);
  endtask
  // One core access; latency, selects seen, strobe length, address and read data are judged.
  task automatic bus_op(input logic wr, input logic [21:0] a, input logic [7:0] d, input logic ihit,
                        input int lat, input logic [2:0] cs);
    int         n;
    int         n_strb;
    logic [2:0] cs_seen;
    logic [19:0] a_seen;
    n_strb  = 0;
    cs_seen = 3'h7;
    a_seen  = 20'h0;
    @(posedge clk);
    cpu_req     <= 1'b1;
    cpu_wr      <= wr;
    cpu_addr    <= a;
    cpu_wdata   <= d;
    cpu_int_hit <= ihit;
    @(posedge clk);
    cpu_req <= 1'b0;
    // Pass n looks at the cycle that follows the n-th edge after the request was driven.
    for (n = 1; n <= 40; n++)
    begin
      #1;
      cs_seen = cs_seen & {cs2_n, cs1_n, cs0_n};
      if (lat > 1 && r_pin_out[wr ? SBMC_PIN_WR : SBMC_PIN_RD] === 1'b0)
      begin
        n_strb++;
        a_seen = r_pin_out[19:0];
      end
      if (cpu_ack === 1'b1)
        break;
      @(posedge clk);
    end
    chk(26'(n), 26'(lat), "ack latency");
    chk({23'h0, cs_seen}, {23'h0, cs}, "chip selects");
    chk(26'(n_strb), 26'(lat > 1 ? lat - 2 : 0), "strobe length");
    if (lat > 1)
      chk({6'h0, a_seen}, {6'h0, a[19:0]}, "address pins");
    if (lat > 1 && !wr && cs != 3'h7)
      chk({18'h0, cpu_rdata}, {18'h0, d}, "read data");
  endtask
  initial
  begin
    clk = 0; nrst = 0; boot_source_pin = 1; sub_oscillator = 0; reg_wr = 0; reg_rd = 0;
    reg_addr = 4'h0; reg_wdata = 8'h00; cpu_req = 0; cpu_wr = 0; cpu_addr = 22'h0;
    cpu_wdata = 8'h00; cpu_int_hit = 0; cpu_rom_hit = 0;
    do_reset(1'b1);
    rd_reg(SBMC_OFS_MODE, 8'h00, "mode after internal boot");
    chk({25'h0, int_rom_en}, 26'h1, "rom enabled");
    rd_reg(SBMC_OFS_STATUS, 8'h00, "status");
    rd_reg(4'hf, 8'h00, "unmapped read");
    chk({4'h0, r_pin_out}, 26'h03fffff, "port pins idle");
    wr_reg(SBMC_OFS_RDAT0, 8'h5a);
    #41 chk({18'h0, r_pin_out[7:0]}, 26'h5a, "port data on pins");
    wr_reg(SBMC_OFS_PDAT, 8'hc3);
    wr_reg(SBMC_OFS_PDIR, 8'h0f);
    #1 chk({10'h0, p_pin_oe, p_pin_out}, {10'h0, 8'h0f, 8'hc3}, "port P in single chip");
    wr_reg(SBMC_OFS_WAIT, 8'h07);
    bus_op(1'b0, 22'h100000, 8'h00, 1'b0, 1, 3'h7);
    wr_reg(SBMC_OFS_MODE, 8'hc7);
    rd_reg(SBMC_OFS_MODE, 8'hc7, "mode readback");
    chk({25'h0, cpu_max_mode}, 26'h1, "maximum mode");
    wr_reg(SBMC_OFS_MODE, 8'h87);
    #1 chk({25'h0, cpu_max_mode}, 26'h0, "minimum mode");
    for (int w = 0; w < 8; w++)
    begin
      logic [1:0] top;
      logic [2:0] cs;
      top = (w % 3 == 0) ? SBMC_CS0_INT_TOP : (w % 3 == 1) ? SBMC_CS1_TOP : SBMC_CS2_TOP;
      cs  = (w % 3 == 0) ? 3'b110 : (w % 3 == 1) ? 3'b101 : 3'b011;
      wr_reg(SBMC_OFS_WAIT, 8'(w));
      bus_op(1'b1, {top, 20'h00010 + 20'(w)}, 8'ha0 + 8'(w), 1'b0, 5 + w, cs);
      bus_op(1'b0, {top, 20'h00010 + 20'(w)}, 8'ha0 + 8'(w), 1'b0, 5 + w, cs);
    end
    bus_op(1'b0, 22'h300000, 8'h00, 1'b1, 1, 3'h7);
    @(posedge clk) cpu_rom_hit <= 1'b1;
    bus_op(1'b0, 22'h300004, 8'h00, 1'b0, 1, 3'h7);
    @(posedge clk) cpu_rom_hit <= 1'b0;
    @(posedge clk) sub_oscillator <= 1'b1;
    bus_op(1'b1, 22'h200001, 8'h3c, 1'b0, 5, 3'b011);
    @(posedge clk) sub_oscillator <= 1'b0;
    wr_reg(SBMC_OFS_MODE, 8'h80);
    wr_reg(SBMC_OFS_CSDAT, 8'h05);
    #41 chk({23'h0, cs2_n, cs1_n, cs0_n}, 26'h5, "select pins as ports");
    bus_op(1'b1, 22'h300002, 8'h11, 1'b0, 12, 3'b101);
    do_reset(1'b0);
    rd_reg(SBMC_OFS_MODE, 8'h80, "mode after external boot");
    chk({25'h0, int_rom_en}, 26'h0, "rom disabled");
    rd_reg(SBMC_OFS_STATUS, 8'h01, "external boot status");
    wr_reg(SBMC_OFS_MODE, 8'h01);
    rd_reg(SBMC_OFS_MODE, 8'h81, "bus mode locked");
    bus_op(1'b1, 22'h00d7ff, 8'h77, 1'b0, 5, 3'b110);
    @(posedge clk) cpu_rom_hit <= 1'b1;
    bus_op(1'b0, 22'h00d7ff, 8'h77, 1'b0, 5, 3'b110);
    @(posedge clk) cpu_rom_hit <= 1'b0;
    bus_op(1'b1, 22'h010000, 8'h66, 1'b0, 5, 3'b110);
    bus_op(1'b1, 22'h00d800, 8'h55, 1'b0, 5, 3'h7);
    conclude();
  end
  initial
  begin
    #(40 * 20000);
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire
